// >>> hw/qdc_pkg.sv
// package for the quad channel code register bank
package qdc_pkg;
  localparam int unsigned QDC_NUM_CHAN = 4;
  localparam int unsigned QDC_ADDR_W = 8;
  localparam int unsigned QDC_DATA_W = 8;
  localparam logic [7:0] QDC_ADDR_BASE = 8'h10;
  localparam logic [7:0] QDC_ADDR_LAST = 8'h17;
  localparam logic [7:0] QDC_REG_RESET = 8'h00;
  localparam logic [7:0] QDC_RD_NONE = 8'h00;
  localparam logic [7:0] QDC_OFF_CHAN_A_LOW = 8'h10;
  localparam logic [7:0] QDC_OFF_CHAN_A_HIGH = 8'h11;
  localparam logic [7:0] QDC_OFF_CHAN_B_LOW = 8'h12;
  localparam logic [7:0] QDC_OFF_CHAN_B_HIGH = 8'h13;
  localparam logic [7:0] QDC_OFF_CHAN_C_LOW = 8'h14;
  localparam logic [7:0] QDC_OFF_CHAN_C_HIGH = 8'h15;
  localparam logic [7:0] QDC_OFF_CHAN_D_LOW = 8'h16;
  localparam logic [7:0] QDC_OFF_CHAN_D_HIGH = 8'h17;
  localparam int unsigned QDC_LSB_BITS_12 = 4;
  localparam int unsigned QDC_LSB_BITS_10 = 2;
  localparam int unsigned QDC_CODE_W = 12;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } qdc_req_s;
endpackage : qdc_pkg

// >>> hw/qdc_chan.sv
// one channel: low/high code register pair and its full code
`timescale 1ns/1ps
module qdc_chan import qdc_pkg::*; #(
  parameter int unsigned LSB_BITS = QDC_LSB_BITS_12
) (
  input wire logic clk, // device clock
  input wire logic arst_n, // power-on reset, active low
  input wire logic wr_low, // write strobe, low-bits register
  input wire logic wr_high, // write strobe, high-bits register
  input wire logic [7:0] wdata, // write data
  output logic [7:0] low_rd, // low-bits register readback
  output logic [7:0] high_rd, // high-bits register readback
  output logic [8+LSB_BITS-1:0] code // full code to the converter
);
  logic [LSB_BITS-1:0] low_q;
  logic [7:0] high_q;

  // unused low bits are not stored at all so they cannot hold stale data
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      low_q <= QDC_REG_RESET[LSB_BITS-1:0];
      high_q <= QDC_REG_RESET;
    end else begin
      if (wr_low) begin
        low_q <= wdata[7 -: LSB_BITS];
      end
      if (wr_high) begin
        high_q <= wdata;
      end
    end
  end

  assign low_rd = {low_q, {(8-LSB_BITS){1'b0}}};
  assign high_rd = high_q;
  assign code = {high_q, low_q};
endmodule : qdc_chan

// >>> hw/qdc_rd_mux.sv
// read data selection over the eight code registers
`timescale 1ns/1ps
module qdc_rd_mux import qdc_pkg::*; (
  input wire logic [7:0] addr, // register address
  input wire logic [2*QDC_NUM_CHAN-1:0][7:0] regs, // readbacks by index
  output logic hit, // address falls in the bank
  output logic [7:0] rdata // selected readback, zero on a miss
);
  logic [7:0] idx;
  assign hit = (addr >= QDC_ADDR_BASE) && (addr <= QDC_ADDR_LAST);
  assign idx = addr - QDC_ADDR_BASE;
  assign rdata = hit ? regs[idx[2:0]] : QDC_RD_NONE;
endmodule : qdc_rd_mux

// >>> hw/qdc_bank.sv
// quad channel code register bank, top level
// Overview of operation
// - four low/high pairs at 0x10..0x17, channel A first, low even
// - high register is eight read/write code MSBs, bit 7 is MSB
// - low register keeps 4 or 2 LSBs in its top bits per variant
// - code is high register above low significant bits, to converter
// - channels are independent; writes touch only their own channel
// - reset clears every code register bit to zero
// - outputs start at code zero and hold until a new write
`timescale 1ns/1ps
module qdc_bank import qdc_pkg::*; #(
  parameter int unsigned LSB_BITS = QDC_LSB_BITS_12 // 4 or 2 code LSBs
) (
  input wire logic clk, // device clock, 25 MHz
  input wire logic arst_n, // power-on reset, active low
  input wire qdc_req_s req, // register access from the serial interface
  output logic hit, // access address lies in the bank
  output logic [7:0] rdata, // registered read data
  output logic rvalid, // read data valid, one-cycle pulse
  output logic [QDC_NUM_CHAN-1:0][8+LSB_BITS-1:0] codes // codes, A at 0
);
  logic [2*QDC_NUM_CHAN-1:0][7:0] regs_rd;
  logic [7:0] idx;
  logic [7:0] mux_data;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic wr_hit;

  assign idx = req.addr - QDC_ADDR_BASE;
  assign wr_hit = req.wr && hit;

  for (genvar c = 0; c < QDC_NUM_CHAN; c++) begin : g_chan
    logic sel;
    // low at even, high at odd offset within the pair
    assign sel = wr_hit && (idx[2:1] == 2'(c));
    qdc_chan #(.LSB_BITS(LSB_BITS)) u_chan (
      .clk(clk),
      .arst_n(arst_n),
      .wr_low(sel && !idx[0]),
      .wr_high(sel && idx[0]),
      .wdata(req.wdata),
      .low_rd(regs_rd[2*c]),
      .high_rd(regs_rd[2*c+1]),
      .code(codes[c])
    );
  end

  qdc_rd_mux u_mux (
    .addr(req.addr),
    .regs(regs_rd),
    .hit(hit),
    .rdata(mux_data)
  );

  // read data registered so the serial shifter sees a stable byte
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= QDC_RD_NONE;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= req.rd;
      if (req.rd) begin
        rdata_q <= mux_data;
      end
    end
  end
  assign rdata = rdata_q;
  assign rvalid = rvalid_q;

  // checks
  for (genvar k = 0; k < QDC_NUM_CHAN; k++) begin : g_chk
    a_pair_form: assert property (@(posedge clk) disable iff (!arst_n)
      codes[k] == {regs_rd[2*k+1], regs_rd[2*k][7 -: LSB_BITS]})
      else $error("channel code not formed from its pair");
    a_pad_zero: assert property (@(posedge clk) disable iff (!arst_n)
      regs_rd[2*k][7-LSB_BITS:0] == '0)
      else $error("unused low bits not zero");
  end
  a_rvalid_pulse: assert property (@(posedge clk) disable iff (!arst_n)
    req.rd |=> rvalid)
    else $error("read not answered");
  a_rvalid_drop: assert property (@(posedge clk) disable iff (!arst_n)
    !req.rd |=> !rvalid)
    else $error("read valid without a read");
  a_miss_read: assert property (@(posedge clk) disable iff (!arst_n)
    req.rd && !hit |=> rdata == QDC_RD_NONE)
    else $error("read outside bank not zero");
  a_miss_write: assert property (@(posedge clk) disable iff (!arst_n)
    req.wr && !hit |=> $stable(codes))
    else $error("write outside bank changed a code");
  a_reset_read: assert property (@(posedge clk)
    $rose(arst_n) |-> rdata == QDC_RD_NONE && !rvalid)
    else $error("read path not cleared by reset");
  a_reset_zero: assert property (@(posedge clk)
    $rose(arst_n) |-> codes == '0)
    else $error("codes not zero after reset");
  a_high_write: assert property (@(posedge clk) disable iff (!arst_n)
    req.wr && req.addr == QDC_OFF_CHAN_A_HIGH |=>
    regs_rd[1] == $past(req.wdata))
    else $error("high register not written");
  a_low_unused: assert property (@(posedge clk) disable iff (!arst_n)
    regs_rd[0][7-LSB_BITS:0] == '0)
    else $error("unused low bits not zero");
  a_low_write: assert property (@(posedge clk) disable iff (!arst_n)
    req.wr && req.addr == QDC_OFF_CHAN_B_LOW |=>
    regs_rd[2][7 -: LSB_BITS] == $past(req.wdata[7 -: LSB_BITS]))
    else $error("low register not written");
  a_code_form: assert property (@(posedge clk) disable iff (!arst_n)
    codes[3] == {regs_rd[7], regs_rd[6][7 -: LSB_BITS]})
    else $error("code not formed from pair");
  a_chan_indep: assert property (@(posedge clk) disable iff (!arst_n)
    req.wr && req.addr == QDC_OFF_CHAN_A_LOW |=>
    $stable(codes[1]) && $stable(codes[2]) && $stable(codes[3]))
    else $error("other channel disturbed");
  a_code_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !req.wr |=> $stable(codes))
    else $error("code changed without write");
  a_map_range: assert property (@(posedge clk) disable iff (!arst_n)
    hit == (req.addr >= QDC_OFF_CHAN_A_LOW &&
            req.addr <= QDC_OFF_CHAN_D_HIGH))
    else $error("bank decode wrong");
  a_read_back: assert property (@(posedge clk) disable iff (!arst_n)
    req.rd && req.addr == QDC_OFF_CHAN_C_HIGH |=>
    rvalid && rdata == regs_rd[5])
    else $error("readback wrong");
  c_write_a: cover property (@(posedge clk)
    req.wr && req.addr == QDC_OFF_CHAN_A_HIGH);
  c_write_d: cover property (@(posedge clk)
    req.wr && req.addr == QDC_OFF_CHAN_D_LOW);
  c_read_hit: cover property (@(posedge clk) req.rd && hit);
  c_write_miss: cover property (@(posedge clk) req.wr && !hit);
  c_reset_gone: cover property (@(posedge clk) $rose(arst_n));
endmodule : qdc_bank

// >>> verification/tb_qdc_bank.sv
// self-checking testbench for the quad channel code register bank
`timescale 1ns/1ps
module tb_qdc_bank;
  import qdc_pkg::*;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } qdc_row_s;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  qdc_req_s req = '0;
  logic hit;
  logic [7:0] rdata;
  logic rvalid;
  logic [QDC_NUM_CHAN-1:0][11:0] codes;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  // low rows keep only the top four bits, the rest must read back zero
  qdc_row_s rows [8] = '{'{8'h10, 8'hff, 8'hf0}, '{8'h11, 8'hab, 8'hab},
    '{8'h12, 8'h5a, 8'h50}, '{8'h13, 8'h12, 8'h12},
    '{8'h14, 8'h3c, 8'h30}, '{8'h15, 8'hc3, 8'hc3},
    '{8'h16, 8'h0f, 8'h00}, '{8'h17, 8'h80, 8'h80}};

  qdc_bank #(.LSB_BITS(4)) u_qdc_bank (.clk(clk), .arst_n(arst_n),
    .req(req), .hit(hit), .rdata(rdata), .rvalid(rvalid), .codes(codes));

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [11:0] s, input logic [11:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  // one request for one cycle; read data is looked at the cycle after
  task automatic acc(input logic w, input logic r, input logic [7:0] a,
                     input logic [7:0] d, input logic [7:0] e);
    logic h;
    h = (a >= QDC_ADDR_BASE) && (a <= QDC_ADDR_LAST);
    @(posedge clk);
    req <= '{wr: w, rd: r, addr: a, wdata: d};
    #1 chk(hit, h);
    @(posedge clk);
    req <= '0;
    #1 if (r) begin
      chk(rvalid, 1'b1);
      chk(rdata, e);
    end
  endtask : acc

  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      fails++;
      give_verdict;
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    for (int c = 0; c < 4; c++) chk(codes[c], 12'h000);
    for (int i = 0; i < 8; i++) acc(0, 1, rows[i].a, 8'h00, 8'h00);
    for (int i = 0; i < 8; i++) begin
      acc(1, 0, rows[i].a, rows[i].d, 8'h00);
      acc(0, 1, rows[i].a, 8'h00, rows[i].e);
      for (int j = 0; j < 4; j++)
        if (j > i / 2) chk(codes[j], 12'h000);
    end
    for (int c = 0; c < 4; c++)
      chk(codes[c], {rows[2*c+1].e, rows[2*c].e[7:4]});
    // write and read in one cycle: the read must see the old byte
    acc(1, 1, 8'h11, 8'h55, 8'hab);
    chk(codes[0], 12'h55f);
    chk(codes[1], 12'h125);
    acc(1, 1, 8'h18, 8'hff, 8'h00);
    acc(1, 0, 8'h0f, 8'hff, 8'h00);
    chk(codes[0], 12'h55f);
    chk(codes[3], 12'h800);
    // reset in mid-run must clear every code without a clock
    @(posedge clk);
    arst_n <= 1'b0;
    #1 for (int c = 0; c < 4; c++) chk(codes[c], 12'h000);
    chk(rdata, 8'h00);
    chk(rvalid, 1'b0);
    @(posedge clk);
    arst_n <= 1'b1;
    acc(0, 1, 8'h15, 8'h00, 8'h00);
    give_verdict;
  end
endmodule : tb_qdc_bank
